// file: hw/dram_pin_cfg.svh
// Timing counts, field positions and reset values of the DRAM pin sequencer.
// Assumes a 100 MHz core clock; included by the package ahead of the modules.
`ifndef DRAM_PIN_CFG_SVH
`define DRAM_PIN_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_PERIOD_NS   10
`define DETECT_WAIT_NS  100
`define DETECT_WAIT_CYC ((`DETECT_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TDQZ_CYC        2

// ****************************************************************
// Field widths and positions
// ****************************************************************
`define ADDR_W          12
`define LANE_W          8
`define ROW_W           4
`define HIT_W           5
`define FIFTH_ROW_BIT   4
`define KIND_W          2
`define DET_CNT_W       8

// ****************************************************************
// Reset values
// ****************************************************************
`define ROW_STROBE_RST  4'hF
`define LANE_RST        8'hFF
`define PAIR_RST        2'h3
`define ADDR_RST        12'h000
`define KIND_RST        2'h0

`endif

// file: hw/dram_pin_pkg.sv
// Types shared by the DRAM pin sequencer, its row model and its bench.
// Assumes dram_pin_cfg.svh is on the include path.
`include "dram_pin_cfg.svh"

package dram_pin_pkg;

  // ****************************************************************
  // Fifth row memory kind and detection states
  // ****************************************************************
  typedef enum logic [`KIND_W-1:0] {
    FIFTH_NONE = 2'h0,
    FIFTH_PAGE = 2'h1,
    FIFTH_SYNC = 2'h2
  } fifth_kind_type;

  typedef enum logic [0:0] {
    DET_WAIT   = 1'h0,
    DET_LOCKED = 1'h1
  } det_state_type;

  // ****************************************************************
  // Request from the timing engine, one per clock
  // ****************************************************************
  typedef struct packed {
    logic [`HIT_W-1:0]  row_hit;
    logic [`LANE_W-1:0] lanes;
    logic               col;
    logic               sd_ras;
    logic               sd_cas;
    logic               we;
    logic               rd;
    logic               mux_sel;
    logic [`ADDR_W-1:0] addr;
  } req_type;

  // ****************************************************************
  // Memory side pins
  // ****************************************************************
  typedef struct packed {
    logic [`ROW_W-1:0]  row_strobe_n;
    logic               fifth_shared_pin;
    logic [`LANE_W-1:0] col_strobe_mask;
    logic               sync_row_strobe_copy_a;
    logic               sync_row_strobe_copy_b;
    logic [1:0]         sync_column_strobe_pair;
    logic [1:0]         write_enable_n_pair;
    logic [`ADDR_W-1:0] multiplexed_memory_address;
  } pins_type;

  typedef struct packed {
    pins_type                pins;
    fifth_kind_type          kind;
    det_state_type           det;
    logic [`DET_CNT_W-1:0]   cnt;
    logic [`KIND_W-1:0]      strap_s1;
    logic [`KIND_W-1:0]      strap_s2;
  } state_type;

endpackage : dram_pin_pkg

// file: hw/lane_delay.sv
// Fixed delay line for read lane flags.
// Assumes a synchronous clock and an already synchronised active low reset.
`timescale 1ns/100ps

module lane_delay #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_sync_n,
  input  wire logic [WIDTH-1:0] in_data,
  output logic      [WIDTH-1:0] out_data
);

  logic [DEPTH-1:0][WIDTH-1:0] stage_q;
  logic [DEPTH-1:0][WIDTH-1:0] stage_d;

  generate
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad
      $error("lane_delay needs positive WIDTH and DEPTH.");
    end
  endgenerate

  always_comb begin
    stage_d = stage_q;
    stage_d[0] = in_data;
    for (int i = 1; i < DEPTH; i++) begin
      stage_d[i] = stage_q[i-1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign out_data = stage_q[DEPTH-1];

endmodule : lane_delay

// file: hw/dram_pin_sequencing.sv
// Memory side pin sequencer of a five row DRAM controller.
// Assumes a timing engine on core_clk issuing one request per cycle and a
// fifth row memory kind strap that comes from the board.
//
// Function
// - Page-mode rows: assert the selected row's low-active row strobe.
// - Synchronous rows: same pins are chip selects; modules act only when low.
// - Fifth row kind caught at power-up picks chip select or mux select.
// - Page-mode rows: eight low-active column strobes choose the byte lanes.
// - Synchronous reads: masks act as output enables after the latency.
// - Synchronous writes: masks are byte write masks with zero latency.
// - Synchronous row strobe low captures row address; activate and precharge.
// - Column strobe and write enable copies carry equal values; row strobe copies do too unless the fifth row is page-mode.
// - Page-mode fifth row turns the second row strobe copy into its strobe.
// - Synchronous column strobe low captures column address for access.
// - Row and column addresses share one twelve-bit multiplexed bus.
// - Low-active write enable marks writes for every memory kind.
`timescale 1ns/100ps

module dram_pin_sequencing
  import dram_pin_pkg::*;
#(
  parameter int TDQZ       = `TDQZ_CYC,
  parameter int DETECT_CYC = `DETECT_WAIT_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic [`KIND_W-1:0]         fifth_row_strap,
  input  wire logic [`ROW_W-1:0]          row_is_sync,
  input  wire dram_pin_pkg::req_type      req,
  output logic                            req_ready,
  output dram_pin_pkg::pins_type          pins,
  output dram_pin_pkg::fifth_kind_type    fifth_kind,
  output logic [`LANE_W-1:0]              read_lanes_due
);
  import dram_pin_pkg::*;

  // ****************************************************************
  // Parameter checks and reset release
  // ****************************************************************
  generate
    if (TDQZ < 1 || TDQZ > 8) begin : g_bad_tdqz
      $error("TDQZ must lie between 1 and 8 cycles.");
    end
    if (DETECT_CYC < 2 || DETECT_CYC > 255) begin : g_bad_det
      $error("DETECT_CYC must lie between 2 and 255 cycles.");
    end
  endgenerate

  logic rst_s1_q;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic hits_sync(input logic [`HIT_W-1:0] hit,
                                     input logic [`ROW_W-1:0] low_sync,
                                     input logic              fifth_sync);
    hits_sync = |(hit & {fifth_sync, low_sync});
  endfunction : hits_sync

  function automatic fifth_kind_type decode_kind(
    input logic [`KIND_W-1:0] strap);
    case (strap)
      2'h1:    decode_kind = FIFTH_PAGE;
      2'h2:    decode_kind = FIFTH_SYNC;
      default: decode_kind = FIFTH_NONE;
    endcase
  endfunction : decode_kind

  // ****************************************************************
  // State
  // ****************************************************************
  localparam state_type STATE_RST = '{
    pins: '{
      row_strobe_n:               `ROW_STROBE_RST,
      fifth_shared_pin:           1'b1,
      col_strobe_mask:            `LANE_RST,
      sync_row_strobe_copy_a:     1'b1,
      sync_row_strobe_copy_b:     1'b1,
      sync_column_strobe_pair:    `PAIR_RST,
      write_enable_n_pair:        `PAIR_RST,
      multiplexed_memory_address: `ADDR_RST
    },
    kind:     FIFTH_NONE,
    det:      DET_WAIT,
    cnt:      '0,
    strap_s1: `KIND_RST,
    strap_s2: `KIND_RST
  };

  state_type state_q;
  state_type state_d;
  logic      is_sync;
  logic      fifth_sync;
  logic      take;
  logic [`LANE_W-1:0] read_lanes_now;

  assign take       = state_q.det == DET_LOCKED;
  assign fifth_sync = state_q.kind == FIFTH_SYNC;
  assign is_sync    = hits_sync(req.row_hit, row_is_sync, fifth_sync);
  assign req_ready  = take;

  always_comb begin
    state_d          = state_q;
    state_d.strap_s1 = fifth_row_strap;
    state_d.strap_s2 = state_q.strap_s1;
    state_d.pins     = STATE_RST.pins;
    case (state_q.det)
      DET_WAIT: begin
        if (state_q.cnt == DETECT_CYC[`DET_CNT_W-1:0]) begin
          state_d.kind = decode_kind(state_q.strap_s2);
          state_d.det  = DET_LOCKED;
        end else begin
          state_d.cnt = state_q.cnt + 1'b1;
        end
      end
      DET_LOCKED: begin
        state_d.kind = state_q.kind;
        for (int i = 0; i < `ROW_W; i++) begin
          state_d.pins.row_strobe_n[i] = ~req.row_hit[i];
        end
        if (is_sync) begin
          state_d.pins.col_strobe_mask = ~req.lanes;
        end else begin
          state_d.pins.col_strobe_mask = ~(req.lanes & {`LANE_W{req.col}});
        end
        state_d.pins.sync_row_strobe_copy_a = ~(is_sync & req.sd_ras);
        state_d.pins.sync_column_strobe_pair =
          {2{~(is_sync & req.sd_cas)}};
        state_d.pins.write_enable_n_pair = {2{~req.we}};
        state_d.pins.multiplexed_memory_address = req.addr;
        case (state_q.kind)
          FIFTH_SYNC: begin
            state_d.pins.fifth_shared_pin =
              ~req.row_hit[`FIFTH_ROW_BIT];
            state_d.pins.sync_row_strobe_copy_b = ~(is_sync & req.sd_ras);
          end
          FIFTH_PAGE: begin
            state_d.pins.fifth_shared_pin = req.mux_sel;
            state_d.pins.sync_row_strobe_copy_b =
              ~req.row_hit[`FIFTH_ROW_BIT];
          end
          default: begin
            state_d.pins.fifth_shared_pin       = req.mux_sel;
            state_d.pins.sync_row_strobe_copy_b = ~(is_sync & req.sd_ras);
          end
        endcase
      end
      default: begin
        state_d = STATE_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign pins       = state_q.pins;
  assign fifth_kind = state_q.kind;

  // ****************************************************************
  // Read lane timing
  // ****************************************************************
  assign read_lanes_now = (take & is_sync & req.rd & req.sd_cas) ?
                          req.lanes : '0;

  lane_delay #(
    .WIDTH (`LANE_W),
    .DEPTH (TDQZ + 1)
  ) u_read_lanes (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .in_data    (read_lanes_now),
    .out_data   (read_lanes_due)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int RD_LAT = TDQZ + 1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  generate
    for (genvar g = 0; g < `ROW_W; g++) begin : g_row_chk
      property p_row_select;
        take && req.row_hit[g] |=> !pins.row_strobe_n[g];
      endproperty
      a_row_select : assert property (p_row_select)
        else $error("Selected row strobe not driven low.");
      property p_row_idle;
        take && !req.row_hit[g] |=> pins.row_strobe_n[g];
      endproperty
      a_row_idle : assert property (p_row_idle)
        else $error("Unselected chip select driven low.");
    end
  endgenerate

  sequence s_sync_req;
    take && is_sync;
  endsequence

  property p_fifth_fixed;
    take |=> $stable(fifth_kind) && take;
  endproperty
  a_fifth_fixed : assert property (p_fifth_fixed)
    else $error("Fifth row function changed after detection.");

  property p_fifth_cs;
    take && fifth_sync |=> pins.fifth_shared_pin == !$past(req.row_hit[4]);
  endproperty
  a_fifth_cs : assert property (p_fifth_cs)
    else $error("Fifth chip select does not follow row hit.");

  property p_page_cas;
    take && !is_sync && req.col
      |=> pins.col_strobe_mask == ~$past(req.lanes);
  endproperty
  a_page_cas : assert property (p_page_cas)
    else $error("Column strobes do not match byte lanes.");

  property p_read_due;
    s_sync_req ##0 (req.rd && req.sd_cas)
      |-> ##RD_LAT read_lanes_due == $past(req.lanes, RD_LAT);
  endproperty
  a_read_due : assert property (p_read_due)
    else $error("Read lanes not due after mask latency.");

  property p_write_mask;
    s_sync_req ##0 req.we |=> pins.col_strobe_mask == ~$past(req.lanes)
      && pins.write_enable_n_pair == 2'h0;
  endproperty
  a_write_mask : assert property (p_write_mask)
    else $error("Write mask not in the write cycle.");

  property p_sync_ras;
    s_sync_req ##0 req.sd_ras |=> !pins.sync_row_strobe_copy_a;
  endproperty
  a_sync_ras : assert property (p_sync_ras)
    else $error("Row strobe not low for activate.");

  property p_copies;
    pins.sync_column_strobe_pair[0] == pins.sync_column_strobe_pair[1]
      && pins.write_enable_n_pair[0] == pins.write_enable_n_pair[1]
      && (fifth_kind == FIFTH_PAGE
          || pins.sync_row_strobe_copy_a == pins.sync_row_strobe_copy_b);
  endproperty
  a_copies : assert property (p_copies)
    else $error("Strobe copies differ.");

  property p_fifth_ras;
    take && fifth_kind == FIFTH_PAGE
      |=> pins.sync_row_strobe_copy_b == !$past(req.row_hit[4]);
  endproperty
  a_fifth_ras : assert property (p_fifth_ras)
    else $error("Fifth row strobe does not follow row hit.");

  property p_sync_cas;
    s_sync_req ##0 req.sd_cas |=> pins.sync_column_strobe_pair == 2'h0;
  endproperty
  a_sync_cas : assert property (p_sync_cas)
    else $error("Column strobe not low for access.");

  property p_addr;
    take |=> pins.multiplexed_memory_address == $past(req.addr);
  endproperty
  a_addr : assert property (p_addr)
    else $error("Address bus does not carry request address.");

  property p_we_idle;
    take && !req.we |=> pins.write_enable_n_pair == 2'h3;
  endproperty
  a_we_idle : assert property (p_we_idle)
    else $error("Write enable low without a write.");

  property p_reset_idle;
    !take |-> pins.row_strobe_n == 4'hF && pins.write_enable_n_pair == 2'h3
      && pins.sync_column_strobe_pair == 2'h3 && pins.col_strobe_mask == 8'hFF;
  endproperty
  a_reset_idle : assert property (p_reset_idle)
    else $error("Strobes active before detection finished.");

  property p_reset_lanes;
    !take |-> read_lanes_due == '0;
  endproperty
  a_reset_lanes : assert property (p_reset_lanes)
    else $error("Read lanes due before detection finished.");

endmodule : dram_pin_sequencing

// file: sim/dram_row_model.sv
// Behavioural rows of memory that sit on the sequencer's pins.
// Assumes registered pins from the sequencer on the same core clock.
`timescale 1ns/100ps

module dram_row_model
  import dram_pin_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire dram_pin_pkg::pins_type pins,
  input  wire logic [`ROW_W-1:0]      row_is_sync,
  input  wire logic                   fifth_sync,
  output logic [15:0]                 cmd_count
);
  logic [`HIT_W-1:0] cs_low;
  logic              any_cmd;

  // ****************************************************************
  // Command acceptance
  // ****************************************************************
  // A synchronous row takes a command only while its select is low.
  assign cs_low  = ~{pins.fifth_shared_pin, pins.row_strobe_n}
                   & {fifth_sync, row_is_sync};
  assign any_cmd = ~pins.sync_row_strobe_copy_a
                   | ~pins.sync_column_strobe_pair[0]
                   | ~pins.write_enable_n_pair[0];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_count <= 16'h0000;
    end else if ((|cs_low) && any_cmd) begin
      cmd_count <= cmd_count + 16'h0001;
    end
  end
endmodule : dram_row_model

// file: sim/dram_pin_sequencing_tb.sv
// Self-checking bench of the DRAM pin sequencer with a row model.
// Assumes the design package and the row model are compiled first.
`timescale 1ns/100ps

module dram_pin_sequencing_tb;
  import dram_pin_pkg::*;
  localparam int TDQZ_T = 2;
  localparam int DET_T  = 2;
  localparam logic [31:0] RST_PINS = {1'b0, 4'hF, 1'b1, 8'hFF, 1'b1,
                                      1'b1, 2'h3, 2'h3, 12'h000};

  logic               core_clk;
  logic               rstn;
  logic [`KIND_W-1:0] fifth_row_strap;
  logic [`ROW_W-1:0]  row_is_sync;
  req_type            req;
  req_type            prev;
  logic               req_ready;
  pins_type           pins;
  fifth_kind_type     fifth_kind;
  fifth_kind_type     kind_e;
  logic [`LANE_W-1:0] read_lanes_due;
  logic [`LANE_W-1:0] hist [0:TDQZ_T];
  logic [15:0]        cmd_count;
  int                 err_count;
  int                 checked;
  int                 cycles;
  int                 exp_cmds;
  int                 seed;

  dram_pin_sequencing #(.TDQZ(TDQZ_T), .DETECT_CYC(DET_T)) i_dram_pin_sequencing (
    .core_clk(core_clk), .rstn(rstn), .fifth_row_strap(fifth_row_strap),
    .row_is_sync(row_is_sync), .req(req), .req_ready(req_ready),
    .pins(pins), .fifth_kind(fifth_kind), .read_lanes_due(read_lanes_due));

  dram_row_model i_dram_row_model (
    .core_clk(core_clk), .rstn(rstn), .pins(pins),
    .row_is_sync(row_is_sync), .fifth_sync(fifth_kind === FIFTH_SYNC),
    .cmd_count(cmd_count));

  // ****************************************************************
  // Clock, timeout and checking helpers
  // ****************************************************************
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("counts: checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic sync_hit(req_type r);
    return |(r.row_hit & {kind_e == FIFTH_SYNC, row_is_sync});
  endfunction : sync_hit

  // Works out the pins that one request must produce.
  function automatic pins_type exp_pins(req_type r);
    pins_type p;
    p.row_strobe_n = ~r.row_hit[3:0];
    p.fifth_shared_pin = (kind_e == FIFTH_SYNC) ? ~r.row_hit[4]
                                                : r.mux_sel;
    p.col_strobe_mask = sync_hit(r) ? ~r.lanes
                                    : ~(r.lanes & {8{r.col}});
    p.sync_row_strobe_copy_a = ~(sync_hit(r) & r.sd_ras);
    p.sync_row_strobe_copy_b = (kind_e == FIFTH_PAGE) ? ~r.row_hit[4]
                               : ~(sync_hit(r) & r.sd_ras);
    p.sync_column_strobe_pair = {2{~(sync_hit(r) & r.sd_cas)}};
    p.write_enable_n_pair = {2{~r.we}};
    p.multiplexed_memory_address = r.addr;
    return p;
  endfunction : exp_pins

  function automatic req_type rand_req();
    req_type     r;
    logic [31:0] v;
    int          h;
    v = $random(seed);
    r = v[30:0];
    h = $unsigned($random(seed)) % 6;
    r.row_hit = (h == 5) ? 5'h00 : 5'h01 << h;
    return r;
  endfunction : rand_req

  // Checks the previous request's pins, then drives the next request.
  task automatic step(req_type r);
    int i;
    r.rd = r.rd & ~r.we & sync_hit(r);
    @(negedge core_clk);
    check("pins", 32'(pins),
          32'(exp_pins(prev)));
    for (i = TDQZ_T; i > 0; i--) begin
      hist[i] = hist[i-1];
    end
    hist[0] = (prev.rd & prev.sd_cas) ? prev.lanes : 8'h00;
    check("read lanes", 32'(read_lanes_due), 32'(hist[TDQZ_T]));
    if (sync_hit(prev) && (prev.sd_ras | prev.sd_cas | prev.we)) begin
      exp_cmds++;
    end
    prev = r;
    req  = r;
  endtask : step

  task automatic run(logic [1:0] strap, logic [3:0] rows, int n);
    int      i;
    req_type c [0:3];
    rstn = 1'b0;
    fifth_row_strap = strap;
    row_is_sync = rows;
    req = '0;
    prev = '0;
    hist = '{default: 8'h00};
    exp_cmds = 0;
    repeat (6) @(negedge core_clk);
    check("reset pins", 32'(pins), RST_PINS);
    check("reset ready", 32'(req_ready), 32'h0);
    rstn = 1'b1;
    kind_e = (strap == 2'h1) ? FIFTH_PAGE :
             (strap == 2'h2) ? FIFTH_SYNC : FIFTH_NONE;
    i = 0;
    while (req_ready !== 1'b1 && i < 40) begin
      req = rand_req();
      @(negedge core_clk);
      if (req_ready !== 1'b1) begin
        check("refused pins", 32'(pins), RST_PINS);
      end
      i++;
    end
    check("kind", 32'(fifth_kind), 32'(kind_e));
    req = '0;
    fifth_row_strap = ~strap;
    c[0] = '{row_hit:5'h01, lanes:8'h0F, rd:1'b1, sd_cas:1'b1,
             addr:12'h00C, default:'0};
    c[1] = '{row_hit:5'h02, lanes:8'hFF, col:1'b1, we:1'b1, default:'0};
    c[2] = '{row_hit:5'h10, sd_ras:1'b1, mux_sel:1'b1, addr:12'hFFF,
             default:'0};
    c[3] = '{row_hit:5'h10, lanes:8'hA5, sd_cas:1'b1, we:1'b1, col:1'b1,
             default:'0};
    for (i = 0; i < 4; i++) begin
      step(c[i]);
    end
    for (i = 0; i < n; i++) begin
      step(rand_req());
    end
    repeat (TDQZ_T + 2) step('0);
    check("kind held", 32'(fifth_kind), 32'(kind_e));
    check("commands", 32'(cmd_count), 32'(exp_cmds));
    $display("test with strap %0d done", strap);
  endtask : run

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    fifth_row_strap = 2'h0;
    row_is_sync = 4'h0;
    req = '0;
    prev = '0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    exp_cmds = 0;
    seed = 32'hb1b7;
    run(2'h2, 4'hF, 150);
    run(2'h1, 4'h5, 150);
    run(2'h0, 4'h0, 100);
    run(2'h3, 4'hA, 100);
    end_sim();
  end
endmodule : dram_pin_sequencing_tb
